// ### design/rscr_cfg.svh
`ifndef RSCR_CFG_SVH
`define RSCR_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define RSCR_OFS_STATUS 8'h00
`define RSCR_OFS_PWDN 8'h01
`define RSCR_OFS_OVRD 8'h02
`define RSCR_OFS_CFG_FIRST 8'h03
`define RSCR_OFS_CFG_LAST 8'h27

// ****************************************
// field positions
// ****************************************
`define RSCR_STRAP_MSB 6
`define RSCR_STRAP_LSB 3
`define RSCR_LOAD_DONE_BIT 2
`define RSCR_RECEIVER_DETECT_OVRD_BIT 7
`define RSCR_RECEIVER_DETECT_VAL_BIT 6
`define RSCR_PRES_BLOCK_BIT 0
`define RSCR_STATUS_WR_MASK 8'h83

// ****************************************
// reset values
// ****************************************
`define RSCR_RST_STATUS 8'h00
`define RSCR_RST_PWDN 8'h00
`define RSCR_RST_OVRD 8'h00
`define RSCR_RST_CFG 8'h00

// ****************************************
// eeprom image layout
// ****************************************
`define RSCR_HDR_CRC_BIT 7
`define RSCR_HDR_MAP_BIT 6
`define RSCR_HDR_SIZE_BIT 5
`define RSCR_HDR_COUNT_MSB 3
`define RSCR_EE_HDR_POS 8'h00
`define RSCR_EE_ENTRY_BASE 8'h04
`define RSCR_EE_FLAT_START 8'h03
`define RSCR_CFG_BLOCK_LEN 6'd37
`define RSCR_CFG_LAST_IDX 6'd36

`endif

// ### design/rscr_pkg.sv
package rscr_pkg;

	// ****************************************
	// management access from the slave engine
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} rscr_bus_req_t;

	// ****************************************
	// register write from the eeprom loader
	// ****************************************
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} rscr_cfg_wr_t;

	typedef struct packed {
		logic crcEnable;
		logic addrMap;
		logic largeImage;
		logic [3:0] deviceCount;
	} rscr_ee_header_t;

	typedef enum logic [2:0] {
		LD_HEADER,
		LD_ENTRY,
		LD_SEEK,
		LD_BLOCK,
		LD_DONE
	} rscr_load_state_t;

endpackage : rscr_pkg

// ### design/rscr_eeprom_loader.sv
`timescale 1ns/100ps
`include "rscr_cfg.svh"

module rscr_eeprom_loader (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] deviceIndex,
	input wire logic eeValid,
	input wire logic [7:0] eeByte,
	output rscr_pkg::rscr_cfg_wr_t cfgWr,
	output rscr_pkg::rscr_ee_header_t header,
	output logic done
);
	import rscr_pkg::*;

	// ****************************************
	// image walker state
	// ****************************************
	rscr_load_state_t state_ff, nxt_state;
	logic [7:0] pos_ff, nxt_pos;
	logic [7:0] start_ff, nxt_start;
	logic [5:0] blkIdx_ff, nxt_blkIdx;
	rscr_ee_header_t hdr_ff, nxt_hdr;
	rscr_cfg_wr_t wr_ff, nxt_wr;
	logic done_ff, nxt_done;
	logic [7:0] entryPos;

	// each start entry is two bytes: the address, then a spare crc byte
	assign entryPos = 8'(`RSCR_EE_ENTRY_BASE + {3'h0, deviceIndex, 1'b0});

	always_comb begin
		nxt_state = state_ff;
		nxt_pos = pos_ff;
		nxt_start = start_ff;
		nxt_blkIdx = blkIdx_ff;
		nxt_hdr = hdr_ff;
		nxt_wr = '0;
		nxt_done = done_ff;
		if (eeValid) begin
			nxt_pos = 8'(pos_ff + 8'h01);
		end
		unique case (state_ff)
			LD_HEADER: begin
				if (eeValid) begin
					nxt_hdr.crcEnable = eeByte[`RSCR_HDR_CRC_BIT];
					nxt_hdr.addrMap = eeByte[`RSCR_HDR_MAP_BIT];
					nxt_hdr.largeImage = eeByte[`RSCR_HDR_SIZE_BIT];
					nxt_hdr.deviceCount = eeByte[`RSCR_HDR_COUNT_MSB:0];
					if (!eeByte[`RSCR_HDR_MAP_BIT]) begin
						nxt_start = `RSCR_EE_FLAT_START;
						nxt_state = LD_SEEK;
					end else if ({1'b0, deviceIndex} >=
						{1'b0, eeByte[`RSCR_HDR_COUNT_MSB:0]}) begin
						// no entry for this device: finish with defaults
						nxt_done = 1'b1;
						nxt_state = LD_DONE;
					end else begin
						nxt_state = LD_ENTRY;
					end
				end
			end
			LD_ENTRY: begin
				if (eeValid && pos_ff == entryPos) begin
					nxt_start = eeByte;
					nxt_state = LD_SEEK;
				end
			end
			LD_SEEK: begin
				if (eeValid && pos_ff == start_ff) begin
					nxt_wr.valid = 1'b1;
					nxt_wr.addr = `RSCR_OFS_CFG_FIRST;
					nxt_wr.data = eeByte;
					nxt_blkIdx = 6'd1;
					nxt_state = LD_BLOCK;
				end else if (eeValid && pos_ff > start_ff) begin
					// block pointed behind us; cannot rewind a stream
					nxt_done = 1'b1;
					nxt_state = LD_DONE;
				end
			end
			LD_BLOCK: begin
				if (eeValid) begin
					nxt_wr.valid = 1'b1;
					nxt_wr.addr = 8'(`RSCR_OFS_CFG_FIRST + {2'h0, blkIdx_ff});
					nxt_wr.data = eeByte;
					nxt_blkIdx = 6'(blkIdx_ff + 6'd1);
					if (blkIdx_ff == `RSCR_CFG_LAST_IDX) begin
						nxt_done = 1'b1;
						nxt_state = LD_DONE;
					end
				end
			end
			LD_DONE: begin
				nxt_done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= LD_HEADER;
			pos_ff <= `RSCR_EE_HDR_POS;
			start_ff <= 8'h00;
			blkIdx_ff <= 6'd0;
			hdr_ff <= '0;
			wr_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pos_ff <= nxt_pos;
			start_ff <= nxt_start;
			blkIdx_ff <= nxt_blkIdx;
			hdr_ff <= nxt_hdr;
			wr_ff <= nxt_wr;
			done_ff <= nxt_done;
		end
	end

	assign cfgWr = wr_ff;
	assign header = hdr_ff;
	assign done = done_ff;

endmodule : rscr_eeprom_loader

// ### design/rscr_regs.sv
// Contract
// - offset 0 bits 6:3 show the four address straps, msb at bit 6.
// - offset 0 bit 2 reads one once the eeprom load has finished.
// - power-down bits disable lanes; 7:4 side A 3:0, 3:0 side B; reset 0.
// - a power-down bit set by the host beats the presence pin.
// - offset 2 bit 7 takes receiver-detect reset away from its automatic source.
// - under that override, bit 6 holds receiver-detect in reset when one.
// - offset 2 bit 0 blocks presence pin control of the lanes; resets 0.
// - eeprom load writes one device block consecutively into offsets 3 to 39.
// - image header gives crc, map, size flags, device count, start entries.
`timescale 1ns/100ps
`include "rscr_cfg.svh"

module rscr_regs (
	input wire logic clk,
	input wire logic rst,
	input wire rscr_pkg::rscr_bus_req_t busReq,
	output logic [7:0] rdData,
	output logic rdValid,
	input wire logic [3:0] addrStrap,
	input wire logic eeValid,
	input wire logic [7:0] eeByte,
	input wire logic presenceInput,
	input wire logic autoRxDetReset,
	output logic [7:0] laneDisable,
	output logic receiverDetectReset,
	output logic loadDone,
	output logic [295:0] cfgImage
);
	import rscr_pkg::*;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic isCfgOffset(input logic [7:0] addr);
		isCfgOffset = (addr >= `RSCR_OFS_CFG_FIRST) &&
			(addr <= `RSCR_OFS_CFG_LAST);
	endfunction : isCfgOffset

	function automatic logic [5:0] cfgIndex(input logic [7:0] addr);
		logic [7:0] diff;
		diff = 8'(addr - `RSCR_OFS_CFG_FIRST);
		cfgIndex = diff[5:0];
	endfunction : cfgIndex

	// host write aimed at one fixed offset
	function automatic logic hostWrite(input rscr_bus_req_t req,
		input logic [7:0] offs);
		hostWrite = req.wr && (req.addr == offs);
	endfunction : hostWrite

	// ****************************************
	// eeprom loader
	// ****************************************
	rscr_cfg_wr_t loadWr;
	logic loaderDone;
	logic [3:0] strap_ff, nxt_strap;

	rscr_eeprom_loader u_loader (
		.clk(clk),
		.rst(rst),
		.deviceIndex(strap_ff),
		.eeValid(eeValid),
		.eeByte(eeByte),
		.cfgWr(loadWr),
		.header(),
		.done(loaderDone)
	);

	// ****************************************
	// strap sampling
	// ****************************************
	// straps are level pins; one stage keeps reads and the loader in step
	always_comb begin
		nxt_strap = addrStrap;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strap_ff <= 4'h0;
		end else begin
			strap_ff <= nxt_strap;
		end
	end

	// ****************************************
	// status register, offset 0
	// ****************************************
	logic [7:0] status_ff, nxt_status;
	logic [7:0] statusView;

	always_comb begin
		nxt_status = status_ff;
		if (hostWrite(busReq, `RSCR_OFS_STATUS)) begin
			// straps and done bit are read-only; only spare bits store
			nxt_status = busReq.data & `RSCR_STATUS_WR_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_ff <= `RSCR_RST_STATUS;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// live status byte: straps and load-done over the stored spare bits
	always_comb begin
		statusView = status_ff & `RSCR_STATUS_WR_MASK;
		statusView[`RSCR_STRAP_MSB:`RSCR_STRAP_LSB] = strap_ff;
		statusView[`RSCR_LOAD_DONE_BIT] = loaderDone;
	end

	// ****************************************
	// lane power-down, offset 1
	// ****************************************
	logic [7:0] pwdn_ff, nxt_pwdn;

	always_comb begin
		nxt_pwdn = pwdn_ff;
		if (hostWrite(busReq, `RSCR_OFS_PWDN)) begin
			nxt_pwdn = busReq.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwdn_ff <= `RSCR_RST_PWDN;
		end else begin
			pwdn_ff <= nxt_pwdn;
		end
	end

	// ****************************************
	// presence and receiver-detect override, offset 2
	// ****************************************
	logic [7:0] ovrd_ff, nxt_ovrd;

	always_comb begin
		nxt_ovrd = ovrd_ff;
		if (hostWrite(busReq, `RSCR_OFS_OVRD)) begin
			nxt_ovrd = busReq.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ovrd_ff <= `RSCR_RST_OVRD;
		end else begin
			ovrd_ff <= nxt_ovrd;
		end
	end

	// ****************************************
	// per-device block, offsets 3 to 39
	// ****************************************
	logic [36:0][7:0] cfgMem_ff, nxt_cfgMem;

	always_comb begin
		nxt_cfgMem = cfgMem_ff;
		// host write lands first; a loader write to the same byte wins
		if (busReq.wr && isCfgOffset(busReq.addr)) begin
			nxt_cfgMem[cfgIndex(busReq.addr)] = busReq.data;
		end
		if (loadWr.valid && isCfgOffset(loadWr.addr)) begin
			nxt_cfgMem[cfgIndex(loadWr.addr)] = loadWr.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfgMem_ff <= {37{`RSCR_RST_CFG}};
		end else begin
			cfgMem_ff <= nxt_cfgMem;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [7:0] rdData_ff, nxt_rdData;
	logic rdValid_ff, nxt_rdValid;

	// data is zero outside the answer cycle so an outer mux can or it
	always_comb begin
		nxt_rdData = 8'h00;
		nxt_rdValid = 1'b0;
		if (busReq.rd) begin
			nxt_rdValid = 1'b1;
			unique case (busReq.addr)
				`RSCR_OFS_STATUS: begin
					nxt_rdData = statusView;
				end
				`RSCR_OFS_PWDN: begin
					nxt_rdData = pwdn_ff;
				end
				`RSCR_OFS_OVRD: begin
					nxt_rdData = ovrd_ff;
				end
				default: begin
					// unmapped offsets read as zero
					if (isCfgOffset(busReq.addr)) begin
						nxt_rdData = cfgMem_ff[cfgIndex(busReq.addr)];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_ff <= 8'h00;
			rdValid_ff <= 1'b0;
		end else begin
			rdData_ff <= nxt_rdData;
			rdValid_ff <= nxt_rdValid;
		end
	end

	// ****************************************
	// lane control
	// ****************************************
	logic pinOff;
	wire [7:0] laneOffNow;
	logic [7:0] laneDisable_ff, nxt_laneDisable;

	// presence low means nothing attached; pin is ignored when blocked
	assign pinOff = ~ovrd_ff[`RSCR_PRES_BLOCK_BIT] & ~presenceInput;

	// one gate per lane; a power-down bit only ever touches its own lane
	genvar lane;
	generate
		for (lane = 0; lane < 8; lane++) begin : g_lane
			// a set power-down bit disables the lane whatever the pin says
			assign laneOffNow[lane] = pwdn_ff[lane] | pinOff;
		end
	endgenerate

	always_comb begin
		nxt_laneDisable = laneOffNow;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			laneDisable_ff <= 8'h00;
		end else begin
			laneDisable_ff <= nxt_laneDisable;
		end
	end

	// ****************************************
	// receiver-detect reset source
	// ****************************************
	logic rxDetReset_ff, nxt_rxDetReset;

	// override hands the reset to the register level, else automatic
	always_comb begin
		if (ovrd_ff[`RSCR_RECEIVER_DETECT_OVRD_BIT]) begin
			nxt_rxDetReset = ovrd_ff[`RSCR_RECEIVER_DETECT_VAL_BIT];
		end else begin
			nxt_rxDetReset = autoRxDetReset;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rxDetReset_ff <= 1'b0;
		end else begin
			rxDetReset_ff <= nxt_rxDetReset;
		end
	end

	// ****************************************
	// load-done flag
	// ****************************************
	logic loadDone_ff, nxt_loadDone;

	// loader holds done until reset, so this copy is sticky as well
	always_comb begin
		nxt_loadDone = loaderDone;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			loadDone_ff <= 1'b0;
		end else begin
			loadDone_ff <= nxt_loadDone;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdData = rdData_ff;
	assign rdValid = rdValid_ff;
	assign laneDisable = laneDisable_ff;
	assign receiverDetectReset = rxDetReset_ff;
	assign loadDone = loadDone_ff;
	assign cfgImage = cfgMem_ff;

endmodule : rscr_regs

// ### verif/rscr_regs_asserts.sv
`timescale 1ns/100ps
module rscr_regs_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire rscr_pkg::rscr_bus_req_t busReq,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic [3:0] addrStrap,
	input wire logic presenceInput,
	input wire logic autoRxDetReset,
	input wire logic [7:0] laneDisable,
	input wire logic receiverDetectReset,
	input wire logic loadDone
);
	import rscr_pkg::*;
	// ****
	// shadow of host writes, offsets 1 and 2 are never loaded
	// ****
	logic [7:0] pwdn_ff;
	logic [7:0] nxt_pwdn;
	logic [7:0] ovrd_ff;
	logic [7:0] nxt_ovrd;
	logic [7:0] expLane;
	logic expRdr;
	always_comb begin
		nxt_pwdn = pwdn_ff;
		nxt_ovrd = ovrd_ff;
		if (busReq.wr && busReq.addr == 8'h01)
			nxt_pwdn = busReq.data;
		if (busReq.wr && busReq.addr == 8'h02)
			nxt_ovrd = busReq.data;
		if (rst) begin
			nxt_pwdn = 8'h00;
			nxt_ovrd = 8'h00;
		end
	end
	always_ff @(posedge clk) begin
		pwdn_ff <= nxt_pwdn;
		ovrd_ff <= nxt_ovrd;
	end
	assign expLane = pwdn_ff | {8{~ovrd_ff[0] & ~presenceInput}};
	assign expRdr = ovrd_ff[7] ? ovrd_ff[6] : autoRxDetReset;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rd_answer: assert property (!$past(rst) |-> rdValid == $past(busReq.rd))
		else $error("read answer not one cycle after request");
	a_rd_quiet: assert property (!rdValid |-> rdData == 8'h00)
		else $error("read data not zero while idle");
	a_strap_view: assert property (
		busReq.rd && busReq.addr == 8'h00 |=> rdData[6:3] == $past(addrStrap, 2))
		else $error("strap bits wrong in status read");
	a_done_bit: assert property (
		busReq.rd && busReq.addr == 8'h00 |=> rdData[2] == loadDone)
		else $error("load done bit differs from done output");
	a_done_sticky: assert property (loadDone |=> loadDone)
		else $error("load done fell without reset");
	a_lane_mix: assert property (
		!$past(rst) |-> laneDisable == $past(expLane))
		else $error("lane disable mix wrong");
	a_receiver_detect_mix: assert property (
		!$past(rst) |-> receiverDetectReset == $past(expRdr))
		else $error("receiver detect reset source wrong");
	a_high_empty: assert property (
		busReq.rd && busReq.addr > 8'h27 |=> rdData == 8'h00)
		else $error("unmapped read not zero");
endmodule : rscr_regs_asserts

bind rscr_regs rscr_regs_asserts u_chk (.clk(clk), .rst(rst), .busReq(busReq),
	.rdData(rdData), .rdValid(rdValid), .addrStrap(addrStrap),
	.presenceInput(presenceInput), .autoRxDetReset(autoRxDetReset),
	.laneDisable(laneDisable), .receiverDetectReset(receiverDetectReset),
	.loadDone(loadDone));

// ### verif/rscr_eeprom_model.sv
`timescale 1ns/100ps
module rscr_eeprom_model (
	input wire logic clk,
	input wire logic go,
	input wire logic slow,
	input wire logic [7:0] hdr,
	input wire logic [7:0] start,
	output logic eeValid,
	output logic [7:0] eeByte
);
	// ****
	// image: header, even bytes hold start, odd bytes their inverted address
	// ****
	logic [7:0] pos = 8'h00;
	logic busy = 1'b0;
	initial eeValid = 1'b0;
	initial eeByte = 8'h00;
	// released line flips so a stale byte never looks valid
	always @(posedge clk) begin
		eeValid <= 1'b0;
		eeByte <= ~eeByte;
		if (go) begin
			pos <= 8'h00;
			busy <= 1'b1;
		end else if (busy && !(slow && eeValid)) begin
			eeValid <= 1'b1;
			eeByte <= (pos == 8'h00) ? hdr : (pos[0] ? ~pos : start);
			pos <= pos + 8'h01;
			busy <= (pos != 8'h5f);
		end
	end
endmodule : rscr_eeprom_model

// ### verif/rscr_regs_tb_top.sv
`timescale 1ns/100ps
module rscr_regs_tb_top;
	import rscr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, go = 1'b1, slow = 1'b0;
	logic presence = 1'b1, autoRx = 1'b0, rdValid, eeValid, rdr, loadDone;
	logic [7:0] hdr = 8'h43, start = 8'h0b, rdData, eeByte, laneDis;
	logic [3:0] strap = 4'h0;
	logic [295:0] cfgImage;
	rscr_bus_req_t req = '0;
	int miscompares = 0, nTests = 0;
	always #50 clk = ~clk;
	rscr_eeprom_model u_ee (.clk(clk), .go(go), .slow(slow), .hdr(hdr),
		.start(start), .eeValid(eeValid), .eeByte(eeByte));
	rscr_regs uut (.clk(clk), .rst(rst), .busReq(req), .rdData(rdData),
		.rdValid(rdValid), .addrStrap(strap), .eeValid(eeValid),
		.eeByte(eeByte), .presenceInput(presence), .autoRxDetReset(autoRx),
		.laneDisable(laneDis), .receiverDetectReset(rdr),
		.loadDone(loadDone), .cfgImage(cfgImage));
	// ****
	// access tasks
	// ****
	task automatic chk(input logic [295:0] seen, exp);
		nTests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk);
		req = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk);
		req = '0;
		chk(rdValid, 1'b1);
		chk(rdData, e);
	endtask : rd
	function automatic logic [295:0] blk(input logic [7:0] s);
		logic [7:0] a;
		blk = '0;
		for (int k = 0; k < 37; k++) begin
			a = s + k[7:0];
			blk[8*k +: 8] = a[0] ? ~a : s;
		end
	endfunction : blk
	// each load needs a fresh reset: the loader wants byte 0 first
	task automatic load(input logic [7:0] h, s, input logic [3:0] st,
		input logic sl, input logic [295:0] ex);
		rst = 1'b1;
		go = 1'b1;
		strap = st;
		hdr = h;
		start = s;
		slow = sl;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		go = 1'b0;
		for (int i = 0; i < 300 && loadDone !== 1'b1; i++)
			@(negedge clk);
		chk(loadDone, 1'b1);
		chk(cfgImage, ex);
		rd(8'h00, {1'b0, st, 3'b100});
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
	endtask : load
	task automatic lane(input logic [7:0] p, o, input logic pr, au);
		presence = pr;
		autoRx = au;
		wr(8'h01, p);
		wr(8'h02, o);
		@(negedge clk);
		chk(laneDis, p | {8{~o[0] & ~pr}});
		chk(rdr, o[7] ? o[6] : au);
		rd(8'h01, p);
		rd(8'h02, o);
	endtask : lane
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	// ****
	// scenarios
	// ****
	initial begin
		load(8'h43, 8'h0b, 4'h0, 1'b0, blk(8'h0b));
		load(8'h43, 8'h0b, 4'h1, 1'b1, blk(8'h0b));
		load(8'h43, 8'h0b, 4'h5, 1'b0, '0);
		load(8'h43, 8'h02, 4'h0, 1'b0, '0);
		load(8'h03, 8'h03, 4'h5, 1'b1, blk(8'h03));
		rd(8'h03, 8'hfc);
		rd(8'h27, 8'hd8);
		wr(8'h00, 8'h7c);
		rd(8'h00, 8'h2c);
		wr(8'h40, 8'h77);
		rd(8'h40, 8'h00);
		lane(8'h00, 8'h00, 1'b1, 1'b0);
		lane(8'hff, 8'h00, 1'b1, 1'b1);
		lane(8'h00, 8'h00, 1'b0, 1'b0);
		lane(8'h00, 8'h01, 1'b0, 1'b1);
		lane(8'ha5, 8'h01, 1'b0, 1'b0);
		lane(8'h00, 8'h80, 1'b1, 1'b1);
		lane(8'h00, 8'hc0, 1'b1, 1'b0);
		lane(8'h3c, 8'hc1, 1'b0, 1'b0);
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end
endmodule : rscr_regs_tb_top
